//--- dv/spp_analog_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// behavioural battery comparators that sit behind the detect logic
module spp_analog_model #(
  parameter int LAG = 3 // settling delay in ns, raise for a slow part
) (
  input wire logic [1:0] battZone,
  input wire logic monEn,
  input wire logic detEn,
  output logic belowLow,
  output logic belowUlt
);
  // comparators only work while the monitor or detector is powered
  assign #LAG belowLow = (monEn | detEn) & (battZone != 2'h0);
  // zone 2 is under both thresholds at once
  assign #LAG belowUlt = (monEn | detEn) & (battZone == 2'h2);
endmodule // spp_analog_model

//--- dv/spp_sleep_power_tb_top.sv
`timescale 1ns/1ps
// compare a design value against the expected one
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  fail_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); \
  end end
////////////////////////////////////////////////////////////////////////////
module spp_sleep_power_tb_top;
  localparam logic [3:0] FACT = 4'hA; // arbitrary factory code
  logic mclk = 1'h0; // system clock
  logic resetn; // async reset, active low
  logic psel, penable, pwrite, sleepEnter, sleepExit;
  logic [11:0] paddr; // bus address
  logic [31:0] pwdata, prdata, rdVal; // bus data
  logic pready, pslverr, rdErr; // bus answer
  logic cmpLow, cmpUlt; // comparator levels
  logic biasEn, convEn, directEn, monEn, detEn, battIrq, battNmi;
  spp_pkg::spp_plan_t powerCtl; // applied supply controls
  logic [2:0] ulpTrim, thrCode; // trim and threshold code
  logic [1:0] battZone; // battery level commanded to the model
  logic [23:0] r; // current table row
  int fail_count = 0; // mismatches
  int compares = 0; // comparisons
  // rows: ctl, cfg, zone, status, {irq,nmi,mon,det}, threshold
  logic [23:0] rows [5] = '{24'h921292, 24'h522392, 24'hD22352,
    24'hF322A7, 24'hD00010};
  always #10 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  spp_sleep_power u_dut (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepEnter(sleepEnter), .sleepExit(sleepExit), .factoryCode(FACT),
    .cmpBelowLow(cmpLow), .cmpBelowUltralow(cmpUlt),
    .converterBiasEn(biasEn), .converterEn(convEn),
    .directSupplyEn(directEn), .powerCtl(powerCtl), .ulpTrim(ulpTrim),
    .battMonitorEn(monEn), .preciseDetectorEn(detEn),
    .thresholdCode(thrCode), .battIrq(battIrq), .battNmi(battNmi));
  spp_analog_model u_model (.battZone(battZone), .monEn(monEn),
    .detEn(detEn), .belowLow(cmpLow), .belowUlt(cmpUlt));
  ////////////////////////////////////////////////////////////////////////
  // one bus transfer: setup, then access until ready is seen
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // ready is sampled at the rising edge; the answer is taken there
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fail_count++;
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // let the edge's updates settle before outputs are looked at
    @(negedge mclk);
  endtask
  // register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  // register read and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rdVal, e)
  endtask
  // one-cycle sleep entry or wake pulse, then settle
  task automatic pulse(input logic ex);
    @(posedge mclk);
    if (ex) sleepExit <= 1'h1;
    else sleepEnter <= 1'h1;
    @(posedge mclk);
    sleepEnter <= 1'h0;
    sleepExit <= 1'h0;
    @(negedge mclk);
  endtask
  // verdict and end of run
  task automatic wrap_up;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // cut a hang short
  initial begin
    #(3000 * 20);
    fail_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    {resetn, psel, penable, pwrite, sleepEnter, sleepExit} = 6'h00;
    paddr = 12'h0;
    pwdata = 32'h0;
    battZone = 2'h0;
    repeat (12) @(posedge mclk);
    resetn <= 1'h1;
    @(negedge mclk);
    `CHK(powerCtl, spp_pkg::PLAN_ALL_ON)
    `CHK({biasEn, convEn, directEn}, 3'h1)
    rdc(spp_pkg::ADR_PLAN, 32'h0000_11DF);
    rdc(spp_pkg::ADR_AUX, {20'h0, FACT, 8'h22});
    rdc(spp_pkg::ADR_CTL, 32'h0);
    rdc(spp_pkg::ADR_CFG, 32'h1);
    rdc(spp_pkg::ADR_STAT, 32'h0);
    // converter bits act at once, planned zeros wait
    wr(spp_pkg::ADR_PLAN, 32'h0000_1600);
    `CHK({biasEn, convEn, directEn}, 3'h6)
    `CHK(powerCtl, spp_pkg::PLAN_ALL_ON)
    pulse(1'h0);
    `CHK(powerCtl, spp_pkg::PLAN_ALL_ON)
    // armed plan applied at sleep entry, arm clears itself
    wr(spp_pkg::ADR_PLAN, 32'h0000_9615);
    rdc(spp_pkg::ADR_PLAN, 32'h0000_9615);
    pulse(1'h0);
    `CHK(powerCtl, 7'h15)
    rdc(spp_pkg::ADR_PLAN, 32'h0000_1615);
    pulse(1'h1);
    `CHK(powerCtl, spp_pkg::PLAN_ALL_ON)
    wr(spp_pkg::ADR_PLAN, 32'h0000_1000);
    `CHK({biasEn, convEn, directEn}, 3'h1)
    // trim written, factory bits untouched
    wr(spp_pkg::ADR_AUX, 32'h0000_0F25);
    rdc(spp_pkg::ADR_AUX, {20'h0, FACT, 8'h25});
    `CHK(ulpTrim, 3'h5)
    // unmapped place answers with an error and zero
    rdc(12'hFF0, 32'h0);
    `CHK(rdErr, 1'h1)
    // battery detect table
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      wr(spp_pkg::ADR_CTL, {28'h0, r[23:20]});
      wr(spp_pkg::ADR_CFG, {28'h0, r[19:16]});
      @(posedge mclk);
      battZone <= r[13:12];
      @(negedge mclk);
      if (i == 0) `CHK(battIrq, 1'h0)
      repeat (3) @(negedge mclk);
      rdc(spp_pkg::ADR_STAT, {28'h0, r[11:8]});
      `CHK({battIrq, battNmi, monEn, detEn}, r[7:4])
      `CHK(thrCode, r[2:0])
    end
    wrap_up();
  end
endmodule // spp_sleep_power_tb_top

//--- hw/spp_pkg.sv
////////////////////////////////////////////////////////////////////////////
// constants and carrier types for the sleep power plan block
package spp_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PLAN = 12'h020;
  localparam logic [11:0] IDX_AUX = 12'h022;
  localparam logic [11:0] IDX_CTL = 12'h024;
  localparam logic [11:0] IDX_CFG = 12'h025;
  localparam logic [11:0] IDX_STAT = 12'h026;
  localparam logic [11:0] ADR_PLAN = {IDX_PLAN[9:0], 2'b00};
  localparam logic [11:0] ADR_AUX = {IDX_AUX[9:0], 2'b00};
  localparam logic [11:0] ADR_CTL = {IDX_CTL[9:0], 2'b00};
  localparam logic [11:0] ADR_CFG = {IDX_CFG[9:0], 2'b00};
  localparam logic [11:0] ADR_STAT = {IDX_STAT[9:0], 2'b00};

  // power plan field positions
  localparam int PLAN_ARM = 15;
  localparam int PLAN_BIAS = 10;
  localparam int PLAN_CONV = 9;
  localparam int PLAN_KEEP_HI = 8;
  localparam int PLAN_SYS = 7;
  localparam int PLAN_RAM16 = 4;
  localparam int PLAN_RAM2 = 0;

  // power plan reset value and writable bits (bit 5 reads zero)
  localparam logic [15:0] PLAN_RST = 16'h11DF;
  localparam logic [15:0] PLAN_WMASK = 16'hFFDF;

  // aux adjust: trim in [2:0], kept field in [5:3], factory in [11:8]
  localparam logic [2:0] TRIM_RST = 3'h2;
  localparam logic [2:0] AUXKEEP_RST = 3'h4;

  // battery control bits
  localparam int CTL_LOWIE = 3;
  localparam int CTL_ULTIE = 2;
  localparam int CTL_MON = 1;
  localparam int CTL_B0 = 0;
  localparam logic [3:0] CTL_RST = 4'h0;
  localparam logic [1:0] CFG_RST = 2'h1;

  // planned supply controls, in register bit order
  typedef struct packed {
    logic mainRegulatorKeep;
    logic systemSupplyKeep;
    logic largeSramRetain;
    logic radioUsbCfgRetain;
    logic coreRetain;
    logic smallSramRetain;
    logic flashKeepPower;
  } spp_plan_t;

  // everything powered, as when awake
  localparam spp_plan_t PLAN_ALL_ON = 7'h7F;

endpackage

//--- hw/spp_sleep_power.sv
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module spp_sleep_power (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepEnter,
  input wire logic sleepExit,
  input wire logic [3:0] factoryCode,
  input wire logic cmpBelowLow,
  input wire logic cmpBelowUltralow,
  output logic converterBiasEn,
  output logic converterEn,
  output logic directSupplyEn,
  output spp_pkg::spp_plan_t powerCtl,
  output logic [2:0] ulpTrim,
  output logic battMonitorEn,
  output logic preciseDetectorEn,
  output logic [2:0] thresholdCode,
  output logic battIrq,
  output logic battNmi
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] plan_r; // power plan register
  logic [15:0] plan_nxt; // its next value
  logic [2:0] auxKeep_r; // kept aux field
  logic [2:0] trim_r; // ulp regulator trim
  logic [3:0] ctl_r; // battery control
  logic [1:0] cfg_r; // threshold select
  logic lowMeta_r; // first sync stage, low
  logic lowSync_r; // synchronised low
  logic ultMeta_r; // first sync stage, ultra-low
  logic ultSync_r; // synchronised ultra-low
  logic [31:0] prdata_r; // registered read data
  logic pready_r; // registered ready
  logic pslverr_r; // registered error
  logic biasEn_r; // converter bias output
  logic convEn_r; // converter output
  logic direct_r; // direct supply output
  spp_pkg::spp_plan_t powerCtl_r; // applied supply controls
  logic monEn_r; // monitor output
  logic detEn_r; // precise detector output
  logic [2:0] thr_r; // threshold code output
  logic irq_r; // interrupt request
  logic nmi_r; // nmi request
  logic [31:0] rdWord; // read mux result
  logic hit; // address is mapped
  logic setup; // apb setup cycle
  logic wr; // write takes effect
  logic wrPlan; // write to plan
  logic wrAux; // write to aux
  logic wrCtl; // write to control
  logic wrCfg; // write to config
  logic applyPlan; // sleep entry with plan armed
  logic ultraStat; // ultra-low status, gated
  logic [2:0] thrNxt; // next threshold code
  logic nmiNxt; // next nmi
  logic irqNxt; // next irq

  ////////////////////////////////////////////////////////////////////////
  // apb strobes
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready_r & pwrite;
  assign wrPlan = wr & (paddr == spp_pkg::ADR_PLAN);
  assign wrAux = wr & (paddr == spp_pkg::ADR_AUX);
  assign wrCtl = wr & (paddr == spp_pkg::ADR_CTL);
  assign wrCfg = wr & (paddr == spp_pkg::ADR_CFG);

  // ultra-low flag only meaningful with the monitor off
  assign ultraStat = ultSync_r & ~ctl_r[spp_pkg::CTL_MON];

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rdWord = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == spp_pkg::ADR_PLAN) begin
      rdWord = {16'h0000, plan_r};
    end else if (paddr == spp_pkg::ADR_AUX) begin
      // factory field is read only and comes from the fuses
      rdWord = {20'h00000, factoryCode, 2'b00, auxKeep_r, trim_r};
    end else if (paddr == spp_pkg::ADR_CTL) begin
      rdWord = {28'h0000000, ctl_r};
    end else if (paddr == spp_pkg::ADR_CFG) begin
      rdWord = {30'h00000000, cfg_r};
    end else if (paddr == spp_pkg::ADR_STAT) begin
      rdWord = {30'h00000000, lowSync_r, ultraStat};
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: ready one cycle after setup, data latched at setup
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~hit;
      if (setup) begin
        prdata_r <= rdWord;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power plan register; a write wins over the self-clear of the arm bit
  assign applyPlan = sleepEnter & plan_r[spp_pkg::PLAN_ARM];

  always_comb begin
    plan_nxt = plan_r;
    if (wrPlan) begin
      // pattern and bit 6 stored as written; bit 5 stays zero
      plan_nxt = pwdata[15:0] & spp_pkg::PLAN_WMASK;
    end else if (applyPlan) begin
      plan_nxt[spp_pkg::PLAN_ARM] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      plan_r <= spp_pkg::PLAN_RST;
    end else begin
      plan_r <= plan_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter bits act at once, from the value being written
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      biasEn_r <= 1'b0;
      convEn_r <= 1'b0;
      direct_r <= 1'b1;
    end else begin
      biasEn_r <= plan_nxt[spp_pkg::PLAN_BIAS];
      convEn_r <= plan_nxt[spp_pkg::PLAN_CONV];
      direct_r <= ~plan_nxt[spp_pkg::PLAN_CONV];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // planned fields reach the supplies only on an armed sleep entry;
  // waking restores full power
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      powerCtl_r <= spp_pkg::PLAN_ALL_ON;
    end else if (applyPlan) begin
      // bits 8..7 then 4..0 map onto the carrier in order
      powerCtl_r <= {plan_r[spp_pkg::PLAN_KEEP_HI:spp_pkg::PLAN_SYS],
                     plan_r[spp_pkg::PLAN_RAM16:spp_pkg::PLAN_RAM2]};
    end else if (sleepExit) begin
      powerCtl_r <= spp_pkg::PLAN_ALL_ON;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // aux adjust: trim and kept field are writable
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trim_r <= spp_pkg::TRIM_RST;
      auxKeep_r <= spp_pkg::AUXKEEP_RST;
    end else if (wrAux) begin
      trim_r <= pwdata[2:0];
      auxKeep_r <= pwdata[5:3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // battery control and threshold config
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= spp_pkg::CTL_RST;
    end else if (wrCtl) begin
      ctl_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= spp_pkg::CFG_RST;
    end else if (wrCfg) begin
      cfg_r <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the comparator outputs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lowMeta_r <= 1'b0;
      lowSync_r <= 1'b0;
      ultMeta_r <= 1'b0;
      ultSync_r <= 1'b0;
    end else begin
      lowMeta_r <= cmpBelowLow;
      lowSync_r <= lowMeta_r;
      ultMeta_r <= cmpBelowUltralow;
      ultSync_r <= ultMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog enables, threshold code and interrupt requests
  always_comb begin
    if (ctl_r[spp_pkg::CTL_MON]) begin
      // monitor on: shared bit is the code's top bit
      thrNxt = {ctl_r[spp_pkg::CTL_B0], cfg_r};
    end else begin
      thrNxt = {1'b0, cfg_r};
    end
  end

  // both enables with ultra-low raise the nmi instead of the irq
  assign nmiNxt = ctl_r[spp_pkg::CTL_LOWIE] & ctl_r[spp_pkg::CTL_ULTIE]
                  & ultraStat;
  assign irqNxt = ~nmiNxt
                  & ((ctl_r[spp_pkg::CTL_LOWIE] & lowSync_r)
                  | (ctl_r[spp_pkg::CTL_ULTIE] & ultraStat));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      monEn_r <= 1'b0;
      detEn_r <= 1'b0;
      // code follows the reset threshold pair from the first cycle
      thr_r <= {1'h0, spp_pkg::CFG_RST};
      irq_r <= 1'b0;
      nmi_r <= 1'b0;
    end else begin
      monEn_r <= ctl_r[spp_pkg::CTL_MON];
      detEn_r <= ~ctl_r[spp_pkg::CTL_MON]
                 & ctl_r[spp_pkg::CTL_B0];
      thr_r <= thrNxt;
      irq_r <= irqNxt;
      nmi_r <= nmiNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign converterBiasEn = biasEn_r;
  assign converterEn = convEn_r;
  assign directSupplyEn = direct_r;
  assign powerCtl = powerCtl_r;
  assign ulpTrim = trim_r;
  assign battMonitorEn = monEn_r;
  assign preciseDetectorEn = detEn_r;
  assign thresholdCode = thr_r;
  assign battIrq = irq_r;
  assign battNmi = nmi_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  // every check runs on the one system clock and sleeps in reset
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_arm_self_clear: assert property (
    applyPlan && !wrPlan |=> !plan_r[spp_pkg::PLAN_ARM] ##1
      !plan_r[spp_pkg::PLAN_ARM] || $past(wrPlan))
    else $error("arm bit did not clear after plan applied");

  a_bias_immediate: assert property (
    wrPlan |=> converterBiasEn == $past(pwdata[10]))
    else $error("bias enable not taken from write");

  a_conv_direct: assert property (
    wrPlan |=> converterEn == $past(pwdata[9])
      && directSupplyEn == !converterEn)
    else $error("converter and direct path disagree");

  a_plan_apply: assert property (
    applyPlan |=> powerCtl == {$past(plan_r[8:7]), $past(plan_r[4:0])})
    else $error("planned fields not applied at sleep entry");

  a_plan_hold: assert property (
    !applyPlan && !sleepExit |=> $stable(powerCtl))
    else $error("supply controls changed outside sleep entry");

  a_trim_write: assert property (
    wrAux |=> ulpTrim == $past(pwdata[2:0]))
    else $error("trim field not updated");

  a_factory_read: assert property (
    setup && paddr == spp_pkg::ADR_AUX |=>
      prdata[11:8] == $past(factoryCode))
    else $error("factory field not read back");

  a_irq_off: assert property (
    ctl_r[3:2] == 2'b00 |=> !battIrq && !battNmi)
    else $error("battery request with enables clear");

  a_nmi_both: assert property (
    ctl_r[3:2] == 2'b11 && ultraStat |=> battNmi && !battIrq)
    else $error("nmi not raised with both enables");

  a_thresh_code: assert property (
    1'b1 |=> thresholdCode ==
      ($past(ctl_r[1]) ? {$past(ctl_r[0]), $past(cfg_r)}
                       : {1'b0, $past(cfg_r)}))
    else $error("threshold code wrong");

  a_status_read: assert property (
    setup && paddr == spp_pkg::ADR_STAT |=>
      prdata[1:0] == {$past(lowSync_r), $past(ultraStat)})
    else $error("status read mismatch");

  a_sync_delay: assert property (
    $rose(lowSync_r) |-> $past(cmpBelowLow, 2))
    else $error("low flag not two stages from comparator");

  // with the monitor off the shared bit powers the precise detector
  a_det_enable: assert property (
    1'b1 |=> preciseDetectorEn == (!$past(ctl_r[1]) && $past(ctl_r[0]))
      && battMonitorEn == $past(ctl_r[1]))
    else $error("monitor or detector enable wrong");

  // low flag with only the low enable raises the plain request
  a_low_irq: assert property (
    ctl_r[3:2] == 2'b10 && lowSync_r |=> battIrq && !battNmi)
    else $error("low battery request missing");

  // with the monitor on the ultra-low flag can never reach the nmi
  a_nmi_masked: assert property (
    ctl_r[1] |=> !battNmi)
    else $error("nmi raised while monitor on");

  // trim only moves on a write to the aux register
  a_trim_hold: assert property (
    !wrAux |=> $stable(ulpTrim))
    else $error("trim changed without a write");

  c_plan_applied: cover property (applyPlan ##[1:50] sleepExit);
  c_nmi_raised: cover property ($rose(battNmi));
  c_bad_addr: cover property (pslverr);
  c_irq_raised: cover property ($rose(battIrq));
  c_monitor_code: cover property (battMonitorEn && thresholdCode[2]);

endmodule // spp_sleep_power
